// ---- logic/ishu_cfg.svh ----
// Register offsets, field positions and reset values of the integer shift unit.
`ifndef ISHU_CFG_SVH
`define ISHU_CFG_SVH
`define ISHU_OFS_CTRL     8'h00
`define ISHU_OFS_SRC      8'h04
`define ISHU_OFS_AMT      8'h08
`define ISHU_OFS_RESULT   8'h0c
`define ISHU_OFS_FLAGS    8'h10
`define ISHU_OFS_STATUS   8'h14
`define ISHU_CTRL_OP_LSB  0
`define ISHU_CTRL_OP_MSB  1
`define ISHU_CTRL_REC_BIT 2
`define ISHU_CTRL_IMM_LSB 8
`define ISHU_CTRL_IMM_MSB 12
`define ISHU_CTRL_GO_BIT  31
`define ISHU_FLG_CA_BIT   0
`define ISHU_FLG_SO_BIT   1
`define ISHU_FLG_CR_LSB   4
`define ISHU_FLG_CR_MSB   7
`define ISHU_STS_DONE_BIT 0
`define ISHU_STS_BUSY_BIT 1
`define ISHU_AMT_BIG_BIT  5
`define ISHU_CR_LT_BIT    3
`define ISHU_CR_GT_BIT    2
`define ISHU_CR_EQ_BIT    1
`define ISHU_CR_SO_BIT    0
`define ISHU_RST_WORD     32'h0000_0000
`define ISHU_RST_CR       4'h0
`define ISHU_RST_IMM      5'h00
`define ISHU_HSIZE_WORD   3'b010
`endif

// ---- logic/ishu_pkg.sv ----
// Types shared by the integer shift unit files.
package ishu_pkg;
  typedef logic [31:0] ishu_word_t;
  typedef enum logic [1:0] {
    OP_SHL_LOG     = 2'b00,
    OP_SHR_LOG     = 2'b01,
    OP_SHR_ALG_IMM = 2'b10,
    OP_SHR_ALG_REG = 2'b11
  } ishu_op_t;
  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_WRITE   = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } ishu_bus_state_t;
endpackage : ishu_pkg

// ---- logic/ishu_shift_core.sv ----
// Combinational barrel shifter with algebraic carry detection.
`timescale 1ns/1ps
module ishu_shift_core #(
  parameter int W  = 32,
  parameter int SW = 5
) (
  // Operation.
  input  wire ishu_pkg::ishu_op_t op,
  input  wire logic [W-1:0]       source_reg,
  input  wire logic [SW:0]        amount,
  input  wire logic [SW-1:0]      imm,
  // Result.
  output logic      [W-1:0]       result,
  output logic                    carry,
  output logic                    carry_upd
);
  function automatic logic [W-1:0] ishu_rev(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int k = 0; k < W; k++) begin
      r[k] = v[W-1-k];
    end
    return r;
  endfunction : ishu_rev

  logic            left;
  logic            arith;
  logic            big;
  logic            fill;
  logic [SW-1:0]   n;
  logic [W-1:0]    stage [SW+1];
  logic [W-1:0]    shifted;
  logic [W-1:0]    lost_mask;

  assign left     = (op == ishu_pkg::OP_SHL_LOG);
  assign arith    = (op == ishu_pkg::OP_SHR_ALG_IMM) || (op == ishu_pkg::OP_SHR_ALG_REG);
  assign big      = (op == ishu_pkg::OP_SHR_ALG_IMM) ? 1'b0 : amount[SW]; // RQ2 RQ8
  assign n        = (op == ishu_pkg::OP_SHR_ALG_IMM) ? imm : amount[SW-1:0]; // RQ4 RQ7
  assign fill     = arith & source_reg[W-1]; // RQ9
  assign stage[0] = left ? ishu_rev(source_reg) : source_reg; // RQ1

  genvar i;
  generate
    for (i = 0; i < SW; i++) begin : g_stage
      localparam int S = 1 << i;
      assign stage[i+1] = n[i] ? {{S{fill}}, stage[i][W-1:S]} : stage[i]; // RQ3
    end
  endgenerate

  assign shifted   = left ? ishu_rev(stage[SW]) : stage[SW];
  assign result    = big ? {W{fill}} : shifted; // RQ2 RQ8
  assign lost_mask = ~({W{1'b1}} << n);
  assign carry     = fill & (big | (|(source_reg & lost_mask))); // RQ5 RQ6 RQ7
  assign carry_upd = arith; // RQ11
endmodule : ishu_shift_core

// ---- logic/ishu_cond_field.sv ----
// Condition field from a result value and the summary overflow bit.
`timescale 1ns/1ps
`include "ishu_cfg.svh"
module ishu_cond_field #(
  parameter int W = 32
) (
  // Inputs.
  input  wire logic [W-1:0] value,
  input  wire logic         so,
  // Field.
  output logic      [3:0]   field
);
  always_comb begin
    field                   = 4'h0;
    field[`ISHU_CR_LT_BIT] = value[W-1]; // RQ10
    field[`ISHU_CR_GT_BIT] = ~value[W-1] & (|value);
    field[`ISHU_CR_EQ_BIT] = ~(|value);
    field[`ISHU_CR_SO_BIT] = so;
  end
endmodule : ishu_cond_field

// ---- logic/ishu_top.sv ----
// Integer shift unit with its AHB-Lite register slave.
// Operation
// [RQ1] Logical left shift by amount bits five to zero, zero fill from the right.
// [RQ2] Logical shifts give all zeros when amount bit five is set.
// [RQ3] Logical right shift by amount bits five to zero, zero fill from the left.
// [RQ4] Immediate algebraic right shift by the immediate field, sign extended result.
// [RQ5] Algebraic shifts set carry only if source negative and ones shifted out.
// [RQ6] Zero immediate copies source unchanged and clears carry.
// [RQ7] Register algebraic shift uses amount bits five to zero; zero copies, clears carry.
// [RQ8] Register algebraic shift with amount bit five set gives all sign bits.
// [RQ9] Register algebraic shift otherwise fills vacated high bits with sign.
// [RQ10] Recording forms update condition field zero from the written result.
// [RQ11] Logical shifts leave carry unchanged; only algebraic shifts modify it.
`timescale 1ns/1ps
`include "ishu_cfg.svh"
module ishu_top (
  // Clock, reset and clock enable.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hce,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Results.
  output logic      [31:0] dest_reg,
  output logic             carry_flag,
  output logic      [3:0]  condition_field_zero,
  output logic             done
);
  ishu_pkg::ishu_bus_state_t state_q;
  logic [7:0]          addr_q;
  logic                size_ok_q;
  logic [31:0]         hrdata_q;
  ishu_pkg::ishu_op_t  op_q;
  logic                rec_q;
  logic [4:0]          imm_q;
  ishu_pkg::ishu_word_t src_q;
  ishu_pkg::ishu_word_t amt_q;
  ishu_pkg::ishu_word_t result_q;
  logic                carry_q;
  logic                so_q;
  logic [3:0]          cr0_q;
  logic                done_q;
  logic                exec_q;
  logic                addr_phase;
  logic                wr_en;
  logic                wr_ctrl;
  logic                wr_src;
  logic                wr_amt;
  logic                wr_flags;
  logic                go;
  logic                exec;
  ishu_pkg::ishu_word_t core_result;
  logic                core_carry;
  logic                core_carry_upd;
  logic [3:0]          core_cr;

  function automatic logic [31:0] ishu_read(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `ISHU_OFS_CTRL: begin
        r[`ISHU_CTRL_OP_MSB:`ISHU_CTRL_OP_LSB]   = op_q;
        r[`ISHU_CTRL_REC_BIT]                    = rec_q;
        r[`ISHU_CTRL_IMM_MSB:`ISHU_CTRL_IMM_LSB] = imm_q;
      end
      `ISHU_OFS_SRC:    r = src_q;
      `ISHU_OFS_AMT:    r = amt_q;
      `ISHU_OFS_RESULT: r = result_q;
      `ISHU_OFS_FLAGS: begin
        r[`ISHU_FLG_CA_BIT]                  = carry_q;
        r[`ISHU_FLG_SO_BIT]                  = so_q;
        r[`ISHU_FLG_CR_MSB:`ISHU_FLG_CR_LSB] = cr0_q;
      end
      `ISHU_OFS_STATUS: begin
        r[`ISHU_STS_DONE_BIT] = done_q;
        r[`ISHU_STS_BUSY_BIT] = exec_q;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : ishu_read

  // Bus phase tracking; reads take one wait state so read data come from a register.
  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout  = (state_q != ishu_pkg::BUS_RD_WAIT);
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ishu_pkg::BUS_IDLE;
      addr_q    <= 8'h00;
      size_ok_q <= 1'b0;
    end else if (hce) begin
      unique case (state_q)
        ishu_pkg::BUS_RD_WAIT: begin
          state_q <= ishu_pkg::BUS_RD_DONE;
        end
        ishu_pkg::BUS_IDLE, ishu_pkg::BUS_WRITE, ishu_pkg::BUS_RD_DONE: begin
          if (addr_phase) begin
            state_q   <= hwrite ? ishu_pkg::BUS_WRITE : ishu_pkg::BUS_RD_WAIT;
            addr_q    <= haddr[7:0];
            size_ok_q <= (hsize == `ISHU_HSIZE_WORD);
          end else begin
            state_q <= ishu_pkg::BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `ISHU_RST_WORD;
    end else if (hce && (state_q == ishu_pkg::BUS_RD_WAIT)) begin
      hrdata_q <= ishu_read(addr_q);
    end
  end

  // Write strobes in the data phase.
  assign wr_en    = hce && (state_q == ishu_pkg::BUS_WRITE) && size_ok_q;
  assign wr_ctrl  = wr_en && (addr_q == `ISHU_OFS_CTRL);
  assign wr_src   = wr_en && (addr_q == `ISHU_OFS_SRC);
  assign wr_amt   = wr_en && (addr_q == `ISHU_OFS_AMT);
  assign wr_flags = wr_en && (addr_q == `ISHU_OFS_FLAGS);
  assign go       = wr_ctrl && hwdata[`ISHU_CTRL_GO_BIT];
  assign exec     = exec_q && hce;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q  <= ishu_pkg::OP_SHL_LOG;
      rec_q <= 1'b0;
      imm_q <= `ISHU_RST_IMM;
    end else if (wr_ctrl) begin
      op_q  <= ishu_pkg::ishu_op_t'(hwdata[`ISHU_CTRL_OP_MSB:`ISHU_CTRL_OP_LSB]);
      rec_q <= hwdata[`ISHU_CTRL_REC_BIT];
      imm_q <= hwdata[`ISHU_CTRL_IMM_MSB:`ISHU_CTRL_IMM_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q <= `ISHU_RST_WORD;
      amt_q <= `ISHU_RST_WORD;
    end else begin
      if (wr_src) begin
        src_q <= hwdata;
      end
      if (wr_amt) begin
        amt_q <= hwdata;
      end
    end
  end

  // Execution runs one cycle after the start bit is written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exec_q <= 1'b0;
    end else if (hce) begin
      exec_q <= go;
    end
  end

  ishu_shift_core #(
    .W  (32),
    .SW (5)
  ) u_core (
    .op         (op_q),
    .source_reg (src_q),
    .amount     (amt_q[`ISHU_AMT_BIG_BIT:0]),
    .imm        (imm_q),
    .result     (core_result),
    .carry      (core_carry),
    .carry_upd  (core_carry_upd)
  );

  ishu_cond_field #(
    .W (32)
  ) u_cond (
    .value (core_result),
    .so    (so_q),
    .field (core_cr)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= `ISHU_RST_WORD;
    end else if (exec) begin
      result_q <= core_result; // RQ1 RQ2 RQ3 RQ4 RQ6 RQ7 RQ8 RQ9
    end
  end

  // Hardware updates win over a software write in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_q <= 1'b0;
    end else if (exec && core_carry_upd) begin
      carry_q <= core_carry; // RQ5 RQ11
    end else if (wr_flags) begin
      carry_q <= hwdata[`ISHU_FLG_CA_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      so_q <= 1'b0;
    end else if (wr_flags) begin
      so_q <= hwdata[`ISHU_FLG_SO_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr0_q <= `ISHU_RST_CR;
    end else if (exec && rec_q) begin
      cr0_q <= core_cr; // RQ10
    end else if (wr_flags) begin
      cr0_q <= hwdata[`ISHU_FLG_CR_MSB:`ISHU_FLG_CR_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (exec) begin
      done_q <= 1'b1;
    end else if (go) begin
      done_q <= 1'b0;
    end
  end

  assign dest_reg             = result_q;
  assign carry_flag           = carry_q;
  assign condition_field_zero = cr0_q;
  assign done                 = done_q;

  // Reference values for the checks below.
  ishu_pkg::ishu_word_t exp_shl;
  ishu_pkg::ishu_word_t exp_shr;
  ishu_pkg::ishu_word_t exp_alg_imm;
  ishu_pkg::ishu_word_t exp_alg_reg;
  logic                 exp_lost_imm;
  logic                 src_sign;

  assign exp_shl      = src_q << amt_q[4:0];
  assign exp_shr      = src_q >> amt_q[4:0];
  assign exp_alg_imm  = $signed(src_q) >>> imm_q;
  assign exp_alg_reg  = $signed(src_q) >>> amt_q[4:0];
  assign exp_lost_imm = |(src_q & ~(32'hffff_ffff << imm_q));
  assign src_sign     = src_q[31];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_exec_op(ishu_pkg::ishu_op_t o);
    exec_q && hce && (op_q == o);
  endsequence

  sequence s_logical;
    s_exec_op(ishu_pkg::OP_SHL_LOG) or s_exec_op(ishu_pkg::OP_SHR_LOG);
  endsequence

  property p_shl_value;
    s_exec_op(ishu_pkg::OP_SHL_LOG) ##0 !amt_q[5] |=> (result_q == $past(exp_shl));
  endproperty
  a_shl_value: assert property (p_shl_value) else $error("left shift result wrong"); // RQ1

  property p_logical_big;
    s_logical ##0 amt_q[5] |=> (result_q == 32'h0000_0000);
  endproperty
  a_logical_big: assert property (p_logical_big) else $error("large logical shift not zero"); // RQ2

  property p_shr_value;
    s_exec_op(ishu_pkg::OP_SHR_LOG) ##0 !amt_q[5] |=> (result_q == $past(exp_shr));
  endproperty
  a_shr_value: assert property (p_shr_value) else $error("right shift result wrong"); // RQ3

  property p_alg_imm_value;
    s_exec_op(ishu_pkg::OP_SHR_ALG_IMM) |=> (result_q == $past(exp_alg_imm));
  endproperty
  a_alg_imm_value: assert property (p_alg_imm_value) else $error("immediate algebraic result wrong"); // RQ4

  property p_carry_set;
    s_exec_op(ishu_pkg::OP_SHR_ALG_IMM) ##0 (src_sign && exp_lost_imm) |=> carry_q;
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry not set"); // RQ5

  property p_carry_pos;
    (s_exec_op(ishu_pkg::OP_SHR_ALG_IMM) or s_exec_op(ishu_pkg::OP_SHR_ALG_REG)) ##0 !src_sign
      |=> !carry_q;
  endproperty
  a_carry_pos: assert property (p_carry_pos) else $error("carry set for positive source"); // RQ5

  property p_imm_zero;
    s_exec_op(ishu_pkg::OP_SHR_ALG_IMM) ##0 (imm_q == 5'h00) |=> (result_q == $past(src_q)) && !carry_q;
  endproperty
  a_imm_zero: assert property (p_imm_zero) else $error("zero immediate not a copy"); // RQ6

  property p_reg_zero;
    s_exec_op(ishu_pkg::OP_SHR_ALG_REG) ##0 (amt_q[5:0] == 6'h00) |=> (result_q == $past(src_q)) && !carry_q;
  endproperty
  a_reg_zero: assert property (p_reg_zero) else $error("zero amount not a copy"); // RQ7

  property p_reg_big;
    s_exec_op(ishu_pkg::OP_SHR_ALG_REG) ##0 amt_q[5] |=> (result_q == {32{$past(src_sign)}}) &&
      (carry_q == $past(src_sign));
  endproperty
  a_reg_big: assert property (p_reg_big) else $error("large algebraic shift not all sign"); // RQ8

  property p_reg_value;
    s_exec_op(ishu_pkg::OP_SHR_ALG_REG) ##0 !amt_q[5] |=> (result_q == $past(exp_alg_reg));
  endproperty
  a_reg_value: assert property (p_reg_value) else $error("register algebraic result wrong"); // RQ9

  property p_record;
    exec_q && hce && rec_q |=> (cr0_q[3] == result_q[31]) && (cr0_q[1] == (result_q == 32'h0000_0000)) &&
      (cr0_q[2] == (!result_q[31] && (result_q != 32'h0000_0000)));
  endproperty
  a_record: assert property (p_record) else $error("condition field not updated"); // RQ10

  property p_logical_carry;
    s_logical ##0 !wr_flags |=> $stable(carry_q);
  endproperty
  a_logical_carry: assert property (p_logical_carry) else $error("logical shift changed carry"); // RQ11

  sequence s_go;
    go ##1 (exec_q && hce);
  endsequence

  property p_go_done;
    s_go |=> done_q && (exec_q == $past(go));
  endproperty
  a_go_done: assert property (p_go_done) else $error("start did not complete");
endmodule : ishu_top

// ---- bench/ishu_seq_model.sv ----
// Bus master model standing in for the instruction sequencer and register file.
`timescale 1ns/1ps
`include "ishu_cfg.svh"
module ishu_seq_model (
  // Clock and bus answer.
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request.
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = `ISHU_HSIZE_WORD;
    hwdata = 32'h0;
  end

  // One single word transfer after an idle gap; released address and data lines show inverted values.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input int gap,
                      output logic [31:0] q);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~a;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : ishu_seq_model

// ---- bench/tb.sv ----
// Self-checking testbench of the integer shift unit.
`timescale 1ns/1ps
`include "ishu_cfg.svh"
module tb;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] dest_reg;
  logic        carry_flag;
  logic [3:0]  condition_field_zero;
  logic        done;
  int          error_cnt;
  int          tests_run;
  int          cycles = 0;
  logic [31:0] lf;
  logic [31:0] q;
  logic [31:0] src;
  logic [5:0]  am;
  logic        m_ca;
  logic        m_so;
  logic [3:0]  m_cr;
  logic        done_q = 1'b0;
  logic [36:0] exp_q[$];
  logic [5:0]  amts [7] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h21, 6'h3f, 6'h00};

  assign hready = hreadyout;

  ishu_top DUT (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
                .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
                .hresp(hresp), .hrdata(hrdata), .dest_reg(dest_reg), .carry_flag(carry_flag),
                .condition_field_zero(condition_field_zero), .done(done));

  ishu_seq_model SEQ (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
                      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  always #10 hclk = ~hclk;

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  task automatic check(input string nm, input logic [39:0] e, input logic [39:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    lf = nxt(lf);
    SEQ.xfer(1'b1, a, d, int'(lf[1:0]), unused);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    lf = nxt(lf);
    SEQ.xfer(1'b0, a, 32'h0, int'(lf[1:0]), d);
  endtask : rd

  // Works out the expected outcome, notes it, runs the shift and reads the result back.
  task automatic run(input logic [1:0] op, input logic rec, input logic [31:0] s, input logic [31:0] amt,
                     input logic [4:0] imm, input int hold = 0);
    int          n;
    logic [63:0] m;
    logic [31:0] r;
    n = (op == 2'h2) ? int'(imm) : (amt[5] ? 32 : int'(amt[4:0]));
    m = (64'h1 << n) - 64'h1;
    case (op)
      2'h0: r = amt[5] ? 32'h0 : s << amt[4:0];
      2'h1: r = amt[5] ? 32'h0 : s >> amt[4:0];
      default: begin
        r = $signed(s) >>> n;
        if (n > 31) begin
          r = {32{s[31]}};
        end
      end
    endcase
    if (op[1]) begin
      m_ca = s[31] & (|(s & m[31:0]));
    end
    if (rec) begin
      m_cr = {r[31], ~r[31] & (r != 32'h0), r == 32'h0, m_so};
    end
    exp_q.push_back({r, m_ca, m_cr});
    wr(`ISHU_OFS_SRC, s);
    wr(`ISHU_OFS_AMT, amt);
    wr(`ISHU_OFS_CTRL, {1'b1, 18'h0, imm, 5'h0, rec, op});
    if (hold > 0) begin
      hce <= 1'b0;
      repeat (hold) @(posedge hclk);
      check("frozen_done", 40'h0, {39'h0, done});
      hce <= 1'b1;
    end
    rd(`ISHU_OFS_RESULT, q);
    check("result_reg", {8'h0, r}, {8'h0, q});
  endtask : run

  // Compares the oldest noted outcome whenever an execution completes.
  always @(posedge hclk) begin
    if (hresetn === 1'b1 && done === 1'b1 && done_q !== 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("[ERR] done expected no completion seen completion");
      end else begin
        check("dest_carry_cond", exp_q.pop_front(), {dest_reg, carry_flag, condition_field_zero});
      end
    end
    done_q <= done;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[ERR] run_length expected 20000 cycles at most seen more");
      results();
    end
  end

  initial begin
    hresetn   = 1'b0;
    hce       = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    lf        = 32'd24;
    m_ca      = 1'b0;
    m_so      = 1'b0;
    m_cr      = 4'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check("reset_outputs", 40'h1, {dest_reg, carry_flag, condition_field_zero, done, hresp, hreadyout});
    rd(`ISHU_OFS_FLAGS, q);
    check("flags_reset", 40'h0, {8'h0, q});
    rd(`ISHU_OFS_STATUS, q);
    check("status_reset", 40'h0, {8'h0, q});
    wr(`ISHU_OFS_RESULT, 32'hffff_ffff);
    rd(`ISHU_OFS_RESULT, q);
    check("result_read_only", 40'h0, {8'h0, q});
    wr(32'h0000_0040, 32'h1234_5678);
    rd(32'h0000_0040, q);
    check("unmapped_read", 40'h0, {8'h0, q});
    wr(`ISHU_OFS_FLAGS, 32'h0000_0003);
    m_ca = 1'b1;
    m_so = 1'b1;
    rd(`ISHU_OFS_FLAGS, q);
    check("flags_rw", 40'h3, {8'h0, q});
    $display("test registers done");
    for (int a = 0; a < 7; a++) begin
      for (int op = 0; op < 4; op++) begin
        lf  = nxt(lf);
        src = nxt(lf);
        am  = (a == 6) ? lf[5:0] : amts[a];
        run(op[1:0], a[0], src, {lf[31:6], am}, am[4:0]);
      end
    end
    run(2'h2, 1'b1, 32'h8000_0000, 32'h0, 5'h1f);
    run(2'h3, 1'b1, 32'h8000_0001, 32'h0000_001f, 5'h00);
    run(2'h0, 1'b0, 32'hffff_ffff, 32'h0, 5'h00);
    run(2'h3, 1'b1, 32'hc000_0003, 32'h0000_0001, 5'h00, 3);
    $display("test shifts done");
    repeat (4) @(posedge hclk);
    check("pending_notes", 40'h0, 40'(exp_q.size()));
    check("bus_response", 40'h0, {39'h0, hresp});
    results();
  end
endmodule : tb
